/* rtl/mbr_pkg.sv */
// Purpose: shared constants for the request handler of the fieldbus i/o node
// Assumes: one byte per clock on the request and response streams
// Notes:   all offsets and codes are those of the frame layout on the wire
package mbr_pkg;
    // ==========================================================
    // function codes
    localparam logic [7:0] READ_INPUT_BITS_CMD        = 8'h02;
    localparam logic [7:0] READ_HOLDING_WORDS_CMD     = 8'h03;
    localparam logic [7:0] READ_INPUT_WORDS_CMD       = 8'h04;
    localparam logic [7:0] WRITE_ONE_OUTPUT_BIT_CMD   = 8'h05;
    localparam logic [7:0] WRITE_ONE_OUTPUT_WORD_CMD  = 8'h06;
    localparam logic [7:0] READ_FIRST_OUTPUT_BYTE_CMD = 8'h07;
    localparam logic [7:0] EXC_FLAG                   = 8'h80;
    // ==========================================================
    // exception codes
    localparam logic [7:0] EXC_NONE  = 8'h00;
    localparam logic [7:0] EXC_FUNC  = 8'h01;
    localparam logic [7:0] EXC_ADDR  = 8'h02;
    localparam logic [7:0] EXC_VALUE = 8'h03;
    localparam logic [7:0] EXC_FAIL  = 8'h04;
    // ==========================================================
    // frame layout: byte positions of the header fields
    localparam logic [3:0] HDR_LEN  = 4'hc;
    localparam int         POS_TID  = 0;
    localparam int         POS_LEN  = 4;
    localparam int         POS_UNIT = 6;
    localparam int         POS_FC   = 7;
    localparam int         POS_ADDR = 8;
    localparam int         POS_QTY  = 10;
    localparam int         POS_DATA = 9;
    localparam int         RSP_MAX  = 25;
    // response totals in bytes, header of six included
    localparam logic [4:0] TOT_SHORT = 5'h09;
    localparam logic [4:0] TOT_ECHO  = 5'h0c;
    localparam logic [4:0] TOT_HEAD  = 5'h06;
    // ==========================================================
    // process image and address map
    localparam logic [15:0] OUT_OFS    = 16'h0200;
    localparam logic [15:0] IN_BITS    = 16'h0040;
    localparam logic [15:0] OUT_BITS   = 16'h0040;
    localparam logic [15:0] IN_WORDS   = 16'h0008;
    localparam logic [15:0] OUT_WORDS  = 16'h0008;
    localparam logic [15:0] COIL_ON    = 16'hff00;
    localparam logic [15:0] COIL_OFF   = 16'h0000;
    localparam int          NBITS      = 64;
    localparam int          NWORDS     = 8;
    // ==========================================================
    // one-hot handler states
    typedef enum logic [2:0] {
        ST_RECV = 3'h1,
        ST_EXEC = 3'h2,
        ST_SEND = 3'h4
    } mbr_state_t;
endpackage

/* rtl/mbr_sync.sv */
// Purpose: two-stage synchroniser for the process input pins
// Assumes: each bit is a slow level; words may tear across one sample
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module mbr_sync #(
    parameter int W = 8
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stg;
    } mbr_sync_t;

    mbr_sync_t s_ff;
    mbr_sync_t nxt_s;

    // ==========================================================
    // next state: shift the pin level through two stages
    always_comb begin
        nxt_s      = s_ff;
        nxt_s.meta = d;
        nxt_s.stg  = s_ff.meta;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign q = s_ff.stg;
endmodule

/* rtl/mbr_handler.sv */
// Purpose: decodes one request frame, updates the output image, builds the reply frame
// Assumes: frames arrive as bytes, first byte first, last byte flagged
// Notes:   one frame at a time; a new frame is taken only after the reply has left
//
// Behaviour
// - function 0x02 returns requested discrete input bits from the input image
// - an input that is on reads as one, off reads as zero
// - first requested bit goes to bit 0 of first data byte, ascending
// - unused high bits of the last data byte are zero
// - bit reply is function code, byte count, packed data bytes; a read of 17 to 24 bits gets the address and quantity echoed instead
// - function 0x03 returns the addressed words of the input image, the same source as 0x04
// - register reply has two bytes per register after byte count twice quantity
// - each register is sent high byte first, then low byte
// - function 0x04 returns input register words, formatted like 0x03
// - function 0x05 writes one output bit; 0xff00 switches it on
// - coil write takes bit address from bytes 8-9 and echoes address and value
// - function 0x06 writes the 16-bit value into the addressed output word
// - register write reply echoes function code, address and value
// - function 0x07 returns one byte: first 8 bits of output image
// - bad request gets exception 0x01 function, 0x02 address, 0x03 value, 0x04 failure
// - read address plus 0x0200 reads back the output image
`timescale 1ns/1ps
module mbr_handler (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              req_valid,
    input  wire logic [7:0]        req_data,
    input  wire logic              req_last,
    output logic                   req_ready,
    output logic                   rsp_valid,
    output logic      [7:0]        rsp_data,
    output logic                   rsp_last,
    input  wire logic              rsp_ready,
    input  wire logic [63:0]       in_bits,
    input  wire logic [7:0][15:0]  in_words,
    input  wire logic              dev_fail,
    output logic      [63:0]       out_bits,
    output logic      [7:0][15:0]  out_words
);
    typedef struct packed {
        mbr_pkg::mbr_state_t state;
        logic [3:0]          cnt;
        logic [11:0][7:0]    hdr;
        logic [24:0][7:0]    rsp;
        logic [4:0]          left;
        logic                exc;
        logic [63:0]         obits;
        logic [7:0][15:0]    owords;
    } mbr_st_t;

    mbr_st_t           s_ff;
    mbr_st_t           nxt_s;
    logic [63:0]       ibits;
    logic [7:0][15:0]  iwords;
    logic              fail;

    // ==========================================================
    // pins of the input image and the fault level cross into mclk
    mbr_sync #(.W(193)) u_sync (
        .mclk (mclk),
        .rst  (rst),
        .d    ({dev_fail, in_words, in_bits}),
        .q    ({fail, iwords, ibits})
    );

    // ==========================================================
    // range check shared by bit and word reads
    function automatic logic area_ok(input logic [15:0] a, input logic [15:0] q,
                                     input logic [15:0] lim_in, input logic [15:0] lim_out);
        logic [16:0] top;
        top = 17'(a) + 17'(q);
        if (a < mbr_pkg::OUT_OFS) begin
            area_ok = top <= 17'(lim_in);
        end else begin
            area_ok = (top - 17'(mbr_pkg::OUT_OFS)) <= 17'(lim_out);
        end
    endfunction

    // ==========================================================
    // next state: receive, execute, send
    always_comb begin
        logic [7:0]  fc;
        logic [15:0] addr;
        logic [15:0] qty;
        logic [15:0] base;
        logic [7:0]  code;
        logic [4:0]  tot;
        logic [63:0] bsrc;
        logic [63:0] bdat;
        logic [7:0][15:0] wsrc;
        logic [15:0] w;
        logic        short_req;
        fc        = s_ff.hdr[mbr_pkg::POS_FC];
        addr      = {s_ff.hdr[mbr_pkg::POS_ADDR], s_ff.hdr[mbr_pkg::POS_ADDR+1]};
        qty       = {s_ff.hdr[mbr_pkg::POS_QTY], s_ff.hdr[mbr_pkg::POS_QTY+1]};
        base      = (addr >= mbr_pkg::OUT_OFS) ? addr - mbr_pkg::OUT_OFS : addr;
        bsrc      = (addr >= mbr_pkg::OUT_OFS) ? s_ff.obits : ibits;
        wsrc      = (addr >= mbr_pkg::OUT_OFS) ? s_ff.owords : iwords;
        code      = mbr_pkg::EXC_NONE;
        tot       = mbr_pkg::TOT_SHORT;
        bdat      = '0;
        w         = '0;
        short_req = s_ff.cnt < mbr_pkg::HDR_LEN;
        nxt_s     = s_ff;
        unique case (s_ff.state)
            mbr_pkg::ST_RECV: begin
                // bytes past the header are swallowed; no request here carries any
                if (req_valid) begin
                    if (s_ff.cnt < mbr_pkg::HDR_LEN) begin
                        nxt_s.hdr[s_ff.cnt] = req_data;
                        nxt_s.cnt           = s_ff.cnt + 4'h1;
                    end
                    if (req_last) begin
                        nxt_s.state = mbr_pkg::ST_EXEC;
                    end
                end
            end
            mbr_pkg::ST_EXEC: begin
                nxt_s.rsp = '0;
                for (int i = 0; i < 4; i++) begin
                    nxt_s.rsp[mbr_pkg::POS_TID+i] = s_ff.hdr[mbr_pkg::POS_TID+i];
                end
                nxt_s.rsp[mbr_pkg::POS_UNIT] = s_ff.hdr[mbr_pkg::POS_UNIT];
                nxt_s.rsp[mbr_pkg::POS_FC]   = fc;
                if (fc == mbr_pkg::READ_INPUT_BITS_CMD) begin
                    if (short_req || qty == 16'h0000 || qty > mbr_pkg::IN_BITS) begin
                        code = mbr_pkg::EXC_VALUE;
                    end else if (!area_ok(addr, qty, mbr_pkg::IN_BITS, mbr_pkg::OUT_BITS)) begin
                        code = mbr_pkg::EXC_ADDR;
                    end else begin
                        // ascending bits from bit 0; beyond the quantity stays zero
                        for (int i = 0; i < mbr_pkg::NBITS; i++) begin
                            if (16'(i) < qty) begin
                                bdat[i] = bsrc[6'(base) + 6'(i)];
                            end
                        end
                        nxt_s.rsp[8] = 8'((qty + 16'h0007) >> 3);
                        for (int b = 0; b < 8; b++) begin
                            nxt_s.rsp[mbr_pkg::POS_DATA+b] = bdat[8*b +: 8];
                        end
                        tot = mbr_pkg::TOT_SHORT + 5'((qty + 16'h0007) >> 3);
                    end
                end else if (fc == mbr_pkg::READ_HOLDING_WORDS_CMD || fc == mbr_pkg::READ_INPUT_WORDS_CMD) begin
                    if (short_req || qty == 16'h0000 || qty > mbr_pkg::IN_WORDS) begin
                        code = mbr_pkg::EXC_VALUE;
                    end else if (!area_ok(addr, qty, mbr_pkg::IN_WORDS, mbr_pkg::OUT_WORDS)) begin
                        code = mbr_pkg::EXC_ADDR;
                    end else begin
                        for (int k = 0; k < mbr_pkg::NWORDS; k++) begin
                            w = (16'(k) < qty) ? wsrc[3'(base) + 3'(k)] : 16'h0000;
                            nxt_s.rsp[mbr_pkg::POS_DATA+2*k]   = w[15:8];
                            nxt_s.rsp[mbr_pkg::POS_DATA+2*k+1] = w[7:0];
                        end
                        nxt_s.rsp[8] = 8'(qty << 1);
                        tot = mbr_pkg::TOT_SHORT + 5'(qty << 1);
                    end
                end else if (fc == mbr_pkg::WRITE_ONE_OUTPUT_BIT_CMD) begin
                    if (short_req) begin
                        code = mbr_pkg::EXC_VALUE;
                    end else if (addr >= mbr_pkg::OUT_BITS) begin
                        code = mbr_pkg::EXC_ADDR;
                    end else if (qty != mbr_pkg::COIL_ON && qty != mbr_pkg::COIL_OFF) begin
                        code = mbr_pkg::EXC_VALUE;
                    end else begin
                        nxt_s.obits[6'(addr)] = (qty == mbr_pkg::COIL_ON);
                        tot = mbr_pkg::TOT_ECHO;
                    end
                end else if (fc == mbr_pkg::WRITE_ONE_OUTPUT_WORD_CMD) begin
                    if (short_req) begin
                        code = mbr_pkg::EXC_VALUE;
                    end else if (addr >= mbr_pkg::OUT_WORDS) begin
                        code = mbr_pkg::EXC_ADDR;
                    end else begin
                        nxt_s.owords[3'(addr)] = qty;
                        tot = mbr_pkg::TOT_ECHO;
                    end
                end else if (fc == mbr_pkg::READ_FIRST_OUTPUT_BYTE_CMD) begin
                    nxt_s.rsp[8] = s_ff.obits[7:0];
                end else begin
                    code = mbr_pkg::EXC_FUNC;
                end
                // write replies are a plain echo of address and value
                if (tot == mbr_pkg::TOT_ECHO) begin
                    for (int i = 8; i < 12; i++) begin
                        nxt_s.rsp[i] = s_ff.hdr[i];
                    end
                end
                // a failed node answers everything with the failure code
                if (fail) begin
                    code = mbr_pkg::EXC_FAIL;
                end
                if (code != mbr_pkg::EXC_NONE) begin
                    nxt_s.rsp[24:8] = '0;
                    // a refused request, a failed node too, must leave both output images alone
                    nxt_s.obits  = s_ff.obits;
                    nxt_s.owords = s_ff.owords;
                    nxt_s.rsp[mbr_pkg::POS_FC] = fc | mbr_pkg::EXC_FLAG;
                    nxt_s.rsp[8] = code;
                    tot = mbr_pkg::TOT_SHORT;
                end
                nxt_s.rsp[mbr_pkg::POS_LEN+1] = 8'(tot - mbr_pkg::TOT_HEAD);
                nxt_s.exc   = code != mbr_pkg::EXC_NONE;
                nxt_s.left  = tot;
                nxt_s.state = mbr_pkg::ST_SEND;
            end
            mbr_pkg::ST_SEND: begin
                // shifting keeps the data output straight off a flop
                if (rsp_ready) begin
                    nxt_s.rsp  = s_ff.rsp >> 8;
                    nxt_s.left = s_ff.left - 5'h01;
                    if (s_ff.left == 5'h01) begin
                        nxt_s.state = mbr_pkg::ST_RECV;
                        nxt_s.cnt   = 4'h0;
                    end
                end
            end
            default: begin
                nxt_s.state = mbr_pkg::ST_RECV;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_ff       <= '0;
            s_ff.state <= mbr_pkg::ST_RECV;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ==========================================================
    // outputs
    assign req_ready = s_ff.state == mbr_pkg::ST_RECV;
    assign rsp_valid = s_ff.state == mbr_pkg::ST_SEND;
    assign rsp_data  = s_ff.rsp[0];
    assign rsp_last  = rsp_valid && s_ff.left == 5'h01;
    assign out_bits  = s_ff.obits;
    assign out_words = s_ff.owords;

    // ==========================================================
    // checks
    logic [7:0]  a_fc;
    logic [15:0] a_addr;
    logic [15:0] a_qty;
    assign a_fc   = s_ff.hdr[mbr_pkg::POS_FC];
    assign a_addr = {s_ff.hdr[8], s_ff.hdr[9]};
    assign a_qty  = {s_ff.hdr[10], s_ff.hdr[11]};

    sequence s_exec_done;
        s_ff.state == mbr_pkg::ST_EXEC ##1 s_ff.state == mbr_pkg::ST_SEND;
    endsequence

    property p_frame_turn;
        @(posedge mclk) disable iff (rst)
        req_valid && req_ready && req_last |=> !req_ready ##1 rsp_valid;
    endproperty
    a_frame_turn: assert property (p_frame_turn) else $error("reply not started two cycles after frame end");

    property p_ids;
        @(posedge mclk) disable iff (rst)
        s_exec_done |-> s_ff.rsp[0] == s_ff.hdr[0] && s_ff.rsp[3] == s_ff.hdr[3] && s_ff.rsp[6] == s_ff.hdr[6]
                        && s_ff.rsp[5] == 8'(s_ff.left - 5'h06);
    endproperty
    a_ids: assert property (p_ids) else $error("reply ids or length wrong");

    property p_exc_fc;
        @(posedge mclk) disable iff (rst)
        s_exec_done ##0 s_ff.exc |-> s_ff.rsp[7] == (a_fc | 8'h80) && s_ff.left == 5'h09;
    endproperty
    a_exc_fc: assert property (p_exc_fc) else $error("exception function code wrong");

    property p_bad_fc;
        @(posedge mclk) disable iff (rst)
        s_ff.state == mbr_pkg::ST_EXEC && !fail && (a_fc == 8'h01 || a_fc > 8'h07) |=> s_ff.rsp[8] == 8'h01;
    endproperty
    a_bad_fc: assert property (p_bad_fc) else $error("illegal function not refused");

    property p_word_count;
        @(posedge mclk) disable iff (rst)
        s_exec_done ##0 (!s_ff.exc && (a_fc == 8'h03 || a_fc == 8'h04)) |-> s_ff.rsp[8] == 8'(a_qty << 1);
    endproperty
    a_word_count: assert property (p_word_count) else $error("word byte count wrong");

    property p_bit_pad;
        @(posedge mclk) disable iff (rst)
        s_exec_done ##0 (!s_ff.exc && a_fc == 8'h02)
        |-> s_ff.rsp[8] == 8'((a_qty + 16'h7) >> 3)
            && ((s_ff.rsp[8 + s_ff.rsp[8]] >> a_qty[2:0]) == 8'h00 || a_qty[2:0] == 3'h0);
    endproperty
    a_bit_pad: assert property (p_bit_pad) else $error("bit reply count or padding wrong");

    property p_coil;
        @(posedge mclk) disable iff (rst)
        s_exec_done ##0 (!s_ff.exc && a_fc == 8'h05) |-> out_bits[a_addr[5:0]] == (a_qty == 16'hff00);
    endproperty
    a_coil: assert property (p_coil) else $error("coil not written");

    property p_word_write;
        @(posedge mclk) disable iff (rst)
        s_exec_done ##0 (!s_ff.exc && a_fc == 8'h06) |-> out_words[a_addr[2:0]] == a_qty && s_ff.rsp[10] == s_ff.hdr[10];
    endproperty
    a_word_write: assert property (p_word_write) else $error("register not written or echoed");

    property p_first_byte;
        @(posedge mclk) disable iff (rst)
        s_exec_done ##0 (!s_ff.exc && a_fc == 8'h07) |-> s_ff.rsp[8] == out_bits[7:0] && s_ff.left == 5'h09;
    endproperty
    a_first_byte: assert property (p_first_byte) else $error("first output byte reply wrong");
endmodule

/* testbench/mbr_master.sv */
// Purpose: fieldbus master partner that feeds request frames and takes reply bytes
// Assumes: drives on the falling edge; the handler samples on the rising edge
// Notes:   slow mode takes a reply byte only every other cycle
`timescale 1ns/1ps
module mbr_master (
    input  wire logic       mclk,
    output logic            req_valid,
    output logic [7:0]      req_data,
    output logic            req_last,
    input  wire logic       req_ready,
    input  wire logic       rsp_valid,
    input  wire logic [7:0] rsp_data,
    input  wire logic       rsp_last,
    output logic            rsp_ready
);
    logic slow;
    // ==========================================================
    // idle levels
    initial begin
        req_valid = 1'b0;
        req_data  = 8'h5a;
        req_last  = 1'b0;
        rsp_ready = 1'b0;
        slow      = 1'b0;
    end
    // ==========================================================
    // ready is a flop output, so its level at the falling edge is what the rising edge sees
    task automatic send(input logic [7:0] f[$]);
        for (int i = 0; i < f.size(); i++) begin
            @(negedge mclk);
            req_valid = 1'b1;
            req_data  = f[i];
            req_last  = (i == f.size() - 1);
            while (!req_ready) @(negedge mclk);
            @(posedge mclk);
        end
        @(negedge mclk);
        req_valid = 1'b0;
        req_last  = 1'b0;
        req_data  = ~req_data;  // released: never show the stale byte
    endtask
    // bounded take loop so a silent handler cannot hang the run
    task automatic recv(output logic [7:0] r[$]);
        logic done;
        r    = {};
        done = 1'b0;
        for (int n = 0; n < 400 && done !== 1'b1; n++) begin
            @(negedge mclk);
            rsp_ready = slow ? n[0] : 1'b1;
            if (rsp_valid === 1'b1 && rsp_ready) begin
                r.push_back(rsp_data);
                done = rsp_last;
            end
            @(posedge mclk);
        end
        @(negedge mclk);
        rsp_ready = 1'b0;
    endtask
endmodule

/* testbench/modbus_tcp_io_request_handler_tb.sv */
// Purpose: self-checking bench for the request handler
// Assumes: inputs change on the falling edge; images need a few cycles to pass the synchroniser
// Notes:   expected replies are built here from the frame layout and a model of the output image
`timescale 1ns/1ps
module modbus_tcp_io_request_handler_tb;
    logic             mclk, rst, dev_fail;
    logic             req_valid, req_last, req_ready, rsp_valid, rsp_last, rsp_ready;
    logic [7:0]       req_data, rsp_data;
    logic [63:0]      in_bits, out_bits, exp_ob;
    logic [7:0][15:0] in_words, out_words, exp_ow;
    logic [15:0]      tid;
    int               failures, compares;

    mbr_handler dut (.mclk(mclk), .rst(rst), .req_valid(req_valid), .req_data(req_data),
        .req_last(req_last), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_last(rsp_last), .rsp_ready(rsp_ready), .in_bits(in_bits), .in_words(in_words),
        .dev_fail(dev_fail), .out_bits(out_bits), .out_words(out_words));
    mbr_master m (.mclk(mclk), .req_valid(req_valid), .req_data(req_data), .req_last(req_last),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last),
        .rsp_ready(rsp_ready));
    // ==========================================================
    // clock and report helpers
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic close_out();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] g, input logic [7:0] e, input string s);
        compares++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: %s got %h exp %h", $time, s, g, e);
        end
    endtask
    task automatic cmp_img(input logic [127:0] g, input logic [127:0] e, input string s);
        compares++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: %s got %h exp %h", $time, s, g, e);
        end
    endtask
    // ==========================================================
    // one frame out, one reply back, compared byte by byte
    task automatic xact(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] q,
                        input logic [7:0] pl[$]);
        logic [7:0] f[$], r[$], e[$];
        tid = tid + 16'h0101;
        f = {tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, (fc == 8'h07) ? 8'h02 : 8'h06, 8'h01, fc};
        if (fc != 8'h07) f = {f, a[15:8], a[7:0], q[15:8], q[7:0]};
        e = {tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, 8'(pl.size() + 1), 8'h01, pl};
        m.send(f);
        m.recv(r);
        cmp8(8'(r.size()), 8'(e.size()), "reply size");
        for (int i = 0; i < e.size() && i < r.size(); i++) cmp8(r[i], e[i], "reply byte");
    endtask
    task automatic rd_bits(input logic [15:0] a, input logic [15:0] q, input logic [63:0] img);
        logic [7:0] pl[$];
        logic [7:0] b;
        pl = {8'h02, 8'((q + 7) / 8)};
        b  = 8'h00;
        for (int i = 0; i < q; i++) begin
            b[i % 8] = img[int'(a[5:0]) + i];
            if (i % 8 == 7 || i == q - 1) begin
                pl.push_back(b);  // unused high bits stay zero
                b = 8'h00;
            end
        end
        xact(8'h02, a, q, pl);
    endtask
    task automatic rd_words(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] q,
                            input logic [7:0][15:0] img);
        logic [7:0] pl[$];
        pl = {fc, 8'(2 * q)};
        for (int i = 0; i < q; i++) pl = {pl, img[int'(a[2:0]) + i][15:8], img[int'(a[2:0]) + i][7:0]};
        xact(fc, a, q, pl);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_bits();
        in_bits = 64'ha5c3_0000_0000_f012;
        repeat (4) @(negedge mclk);
        rd_bits(16'h0000, 16'h0008, in_bits);
        rd_bits(16'h0003, 16'h000a, in_bits);
        rd_bits(16'h0038, 16'h0008, in_bits);
        $display("test bits done");
    endtask
    task automatic t_words();
        in_words = {16'h8001, 16'h7e02, 16'h0003, 16'h1004, 16'h0105, 16'h2345, 16'h1234, 16'hbeef};
        repeat (4) @(negedge mclk);
        rd_words(8'h03, 16'h0001, 16'h0002, in_words);
        m.slow = 1'b1;
        rd_words(8'h04, 16'h0006, 16'h0002, in_words);
        m.slow = 1'b0;
        $display("test words done");
    endtask
    task automatic t_writes();
        xact(8'h05, 16'h0001, 16'hff00, {8'h05, 8'h00, 8'h01, 8'hff, 8'h00});
        xact(8'h05, 16'h003f, 16'hff00, {8'h05, 8'h00, 8'h3f, 8'hff, 8'h00});
        exp_ob = 64'h8000_0000_0000_0002;
        cmp_img(128'(out_bits), 128'(exp_ob), "coil image");
        xact(8'h05, 16'h0001, 16'h0000, {8'h05, 8'h00, 8'h01, 8'h00, 8'h00});
        exp_ob[1] = 1'b0;
        xact(8'h05, 16'h0004, 16'hff00, {8'h05, 8'h00, 8'h04, 8'hff, 8'h00});
        exp_ob[4] = 1'b1;
        cmp_img(128'(out_bits), 128'(exp_ob), "coil image");
        rd_bits(16'h0200, 16'h0008, exp_ob);
        rd_bits(16'h0238, 16'h0008, exp_ob);
        xact(8'h07, 16'h0000, 16'h0000, {8'h07, exp_ob[7:0]});
        xact(8'h06, 16'h0002, 16'h1234, {8'h06, 8'h00, 8'h02, 8'h12, 8'h34});
        exp_ow    = '0;
        exp_ow[2] = 16'h1234;
        cmp_img(out_words, exp_ow, "word image");
        rd_words(8'h03, 16'h0202, 16'h0001, exp_ow);
        $display("test writes done");
    endtask
    task automatic t_exc();
        logic [7:0]  fcs[6] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h04, 8'h10};
        logic [15:0] as[6]  = '{16'h0000, 16'h0000, 16'h0007, 16'h0001, 16'h0000, 16'h0000};
        logic [15:0] qs[6]  = '{16'h0001, 16'h0000, 16'h0002, 16'h1234, 16'h0009, 16'h0001};
        logic [7:0]  cs[6]  = '{8'h01, 8'h03, 8'h02, 8'h03, 8'h03, 8'h01};
        for (int i = 0; i < 6; i++) xact(fcs[i], as[i], qs[i], {fcs[i] | 8'h80, cs[i]});
        cmp_img(128'(out_bits), 128'(exp_ob), "image after refusal");
        dev_fail = 1'b1;
        repeat (4) @(negedge mclk);
        xact(8'h06, 16'h0000, 16'h5555, {8'h86, 8'h04});
        cmp_img(out_words, exp_ow, "word image after failure");
        dev_fail = 1'b0;
        $display("test exceptions done");
    endtask
    // ==========================================================
    // main sequence and watchdog; both end in close_out
    initial begin
        rst      = 1'b1;
        dev_fail = 1'b0;
        in_bits  = '0;
        in_words = '0;
        tid      = 16'h0000;
        failures = 0;
        compares = 0;
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        t_bits();
        t_words();
        t_writes();
        t_exc();
        close_out();
    end
    initial begin
        #(20000 * 4);  // about thirty times the expected run
        failures++;
        $display("unexpected at %0t: watchdog expired", $time);
        close_out();
    end
endmodule
